// >>> oar_operand_addressing.sv
/*
 * oar_operand_addressing: operand address generation and repeat control.
 * Takes one decoded instruction at a time, forms its operand, updates the
 * auxiliary registers and pointer, and re-runs a repeated instruction.
 * Assumes memories answer read requests with a valid strobe some cycles
 * later, and that the interrupt controller honours irqHold.
 * Assumes the bus master holds each request until it sees pready.
 */
// Chosen here: register access over APB and the address map.
`timescale 1ns/10ps

// How it works
// - seven indirect update variants on current aux
// - address from aux first, then update aux/pointer
// - short immediate taken from instruction word field
// - long immediate fetched as second program word
// - register mode reads aux registers, no address
// - repeat count from memory or 8-bit immediate
// - loaded count N gives N+1 executions, long form runs once
// - repeat counter cleared on reset
// - interrupts held off until repeat loop ends
// - repeated instruction completes one per cycle
// - short form one word, long form two
// - aux select fields encode registers 0 to 7
// - direct address is page above 7-bit offset
// - pointer 0 to 7 selects current aux
module oar_operand_addressing (
   input  wire logic                     sys_clk,
   input  wire logic                     rst_b,
   input  wire oar_pkg::oar_instr_t      instr,
   output logic                          instrReady,
   output logic                          progReq,
   input  wire oar_pkg::oar_word_t       progWord,
   output oar_pkg::oar_memreq_t          dataReq,
   input  wire oar_pkg::oar_word_t       dataRd,
   output oar_pkg::oar_opnd_t            opnd,
   output logic                          irqHold,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [oar_pkg::PADDR_W-1:0] paddr,
   input  wire logic [31:0]              pwdata,
   output logic [31:0]                   prdata,
   output logic                          pready,
   output logic                          pslverr
);
   import oar_pkg::*;

   // all state in one packed struct; s_d is the copy filled each cycle
   oar_state_t s_q;
   oar_state_t s_d;

   // ************************************************************
   // helpers
   // ************************************************************

   // bit-reversed steps carry the wrong way; mirroring both operands
   // lets a plain adder do it, and the swaps are only wiring
   // mirror a word so that a normal add carries from msb toward lsb
   function automatic logic [DATA_W-1:0] mirror(input logic [DATA_W-1:0] v);
      logic [DATA_W-1:0] r;
      r = '0;
      for (int b = 0; b < DATA_W; b++) begin
         r[b] = v[DATA_W-1-b];
      end
      return r;
   endfunction

   // shared by the first pass, every repeat pass and the long form,
   // so all of them step aux the same way; repeat passes of table ops take tblAddr as operand
   // limitation: stepping the index register uses its old value
   // one execution: form the operand, then step aux and pointer
   function automatic oar_state_t execOne(input oar_state_t s,
                                          input oar_instr_t i,
                                          input logic [DATA_W-1:0] lw);
      oar_state_t        t;
      logic [DATA_W-1:0] ar;
      logic [DATA_W-1:0] idx;
      t   = s;
      ar  = s.aux[s.ptr];
      idx = s.aux[INDEX_REG];
      t.opnd.valid  = 1'b1;
      t.opnd.isAddr = 1'b0;
      t.opnd.value  = '0;
      t.opnd.last   = 1'b1;

      // operand per mode; only indirect touches aux and pointer
      case (i.mode)
         MODE_DIRECT: begin
            t.opnd.isAddr = 1'b1;
            // page pointer supplies the upper nine bits
            t.opnd.value  = {s.page, i.word[OFS_W-1:0]};
         end

         MODE_INDIRECT: begin
            // address leaves with the old value; the step lands after
            t.opnd.isAddr = 1'b1;
            t.opnd.value  = ar;
            case (i.upd)
               UPD_INC:     t.aux[s.ptr] = ar + 16'h0001;
               UPD_DEC:     t.aux[s.ptr] = ar - 16'h0001;
               UPD_ADD_IDX: t.aux[s.ptr] = ar + idx;
               UPD_SUB_IDX: t.aux[s.ptr] = ar - idx;
               UPD_REV_INC:
                  t.aux[s.ptr] = mirror(mirror(ar) + mirror(idx));
               UPD_REV_DEC:
                  t.aux[s.ptr] = mirror(mirror(ar) - mirror(idx));
               default:     t.aux[s.ptr] = ar;
            endcase
            if (i.loadPtr) begin
               t.ptr = i.nextPtr;
            end
         end

         MODE_SHORT: begin
            // operand sits in the word itself, no further fetch
            t.opnd.value = {8'h00, i.word[SIMM_W-1:0]};
         end

         MODE_LONG: begin
            // lw is the second program word, used whole
            t.opnd.value = lw;
         end

         MODE_REG: begin
            // 16-bit operand straight from the register file
            t.opnd.value = i.implied ? ar : s.aux[i.regSel];
         end
         default: begin
            t.opnd.valid = 1'b0;
         end
      endcase
      return t;
   endfunction

   // ************************************************************
   // register port decode
   // ************************************************************
   // address hit flags and the read data mux
   logic        auxHit;
   logic        anyHit;
   logic [31:0] rdMux;

   // map, one aligned word each, unused upper bits read zero:
   //   aux 0..7   first eight words, aux 0 is the index register
   //   pointer    three bits
   //   page       nine bits
   //   status     counter and flags, read only
   // any other address answers with an error and a zero word
   // aux block occupies the first eight aligned words
   always_comb begin
      auxHit = (paddr[PADDR_W-1:5] == AUX_BASE_OFS[PADDR_W-1:5])
               && (paddr[1:0] == 2'b00);
      anyHit = auxHit || (paddr == PTR_OFS) || (paddr == PAGE_OFS)
               || (paddr == STAT_OFS);
      // bits that no register owns read back as zero
      rdMux  = 32'h0000_0000;
      if (auxHit) begin
         rdMux[DATA_W-1:0] = s_q.aux[paddr[4:2]];
      end else if (paddr == PTR_OFS) begin
         rdMux[PTR_W-1:0] = s_q.ptr;
      end else if (paddr == PAGE_OFS) begin
         rdMux[PAGE_W-1:0] = s_q.page;
      end else if (paddr == STAT_OFS) begin
         rdMux[STAT_CNT_LSB +: DATA_W] = s_q.cnt;
         rdMux[STAT_ARMED_BIT]         = s_q.armed;
         rdMux[STAT_BUSY_BIT]          = (s_q.state != ST_IDLE);
         rdMux[STAT_HOLD_BIT]          = s_q.irqHold;
      end
   end

   // ************************************************************
   // next state
   // ************************************************************
   // apbFirst: first access edge; apbDone: the edge that sees pready
   logic apbFirst;
   logic apbDone;
   logic execLast;

   // bus: the first access edge latches read data and raises pready,
   // the edge that sees pready applies a write: one wait state each
   //
   // core: an instruction is taken where instr.valid meets instrReady
   //   ST_IDLE    take a new instruction
   //   ST_LONG    wait for the second program word
   //   ST_RPTMEM  wait for the repeat count from data memory
   //   ST_REPEAT  re-run the held instruction once per cycle
   // software writes go in first so a core update in the same cycle wins
   always_comb begin
      // defaults: hold all state, drop every one-cycle pulse
      s_d      = s_q;
      apbFirst = psel && penable && !s_q.pready;
      apbDone  = psel && penable && s_q.pready;
      execLast = 1'b0;
      s_d.opnd.valid    = 1'b0;
      s_d.progReq       = 1'b0;
      s_d.dataReq.valid = 1'b0;
      s_d.pready        = apbFirst;   // one wait state, then answer

      // read data and error latch once and stand till the next access
      if (apbFirst) begin
         s_d.prdata  = rdMux;
         s_d.pslverr = !anyHit;
      end

      // a write lands on the edge that sees pready; status ignores it
      if (apbDone && pwrite && anyHit) begin
         if (auxHit) begin
            s_d.aux[paddr[4:2]] = pwdata[DATA_W-1:0];
         end else if (paddr == PTR_OFS) begin
            s_d.ptr = pwdata[PTR_W-1:0];
         end else if (paddr == PAGE_OFS) begin
            s_d.page = pwdata[PAGE_W-1:0];
         end
      end

      // per state: what the core side does this cycle
      case (s_q.state)
         ST_IDLE: begin
            if (instr.valid && s_q.ready) begin
               if (instr.isRepeat) begin
                  // hold interrupts from decode until the loop ends
                  s_d.irqHold = 1'b1;
                  if (instr.mode == MODE_DIRECT ||
                      instr.mode == MODE_INDIRECT) begin
                     // address the count word, load it when it returns
                     s_d = execOne(s_d, instr, '0);
                     s_d.opnd.valid    = 1'b0;
                     s_d.dataReq.valid = 1'b1;
                     s_d.dataReq.addr  = s_d.opnd.value;
                     s_d.state         = ST_RPTMEM;
                  end else begin
                     s_d.cnt   = {8'h00, instr.word[SIMM_W-1:0]};
                     s_d.armed = 1'b1;
                  end
               end else if (instr.mode == MODE_LONG) begin
                  // two-word form: ask for the second word first
                  s_d.cur     = instr;
                  s_d.progReq = 1'b1;
                  s_d.state   = ST_LONG;
               end else begin
                  // with nothing armed the instruction runs once; with
                  // N = 0 it also runs once, and still ends the loop
                  // first of N+1 executions happens right here
                  s_d = execOne(s_d, instr, '0);
                  s_d.cur     = instr;
                  s_d.tblAddr = s_d.opnd.value + 16'h0001;
                  if (s_q.armed && s_q.cnt != '0) begin
                     s_d.cnt       = s_q.cnt - 16'h0001;
                     s_d.opnd.last = 1'b0;
                     s_d.state     = ST_REPEAT;
                  end else begin
                     execLast = 1'b1;
                  end
               end
            end
         end

         ST_RPTMEM: begin
            // instrReady stays low until the count is in
            if (dataRd.valid) begin
               s_d.cnt   = dataRd.data;
               s_d.armed = 1'b1;
               s_d.state = ST_IDLE;
            end
         end

         ST_LONG: begin
            // instrReady stays low until the second word is in
            // long forms are not pipelined under repeat: run once
            if (progWord.valid) begin
               s_d = execOne(s_d, s_q.cur, progWord.data);
               execLast  = 1'b1;
               s_d.state = ST_IDLE;
            end
         end

         ST_REPEAT: begin
            // one iteration per cycle; table ops step one word each
            // instrReady stays low for the whole loop
            s_d = execOne(s_d, s_q.cur, '0);
            if (s_q.cur.tableOp) begin
               s_d.opnd.value = s_q.tblAddr;
               s_d.tblAddr    = s_q.tblAddr + 16'h0001;
            end
            if (s_q.cnt == '0) begin
               execLast  = 1'b1;
               s_d.state = ST_IDLE;
            end else begin
               s_d.cnt       = s_q.cnt - 16'h0001;
               s_d.opnd.last = 1'b0;
            end
         end

         default: begin
            s_d.state = ST_IDLE;
         end
      endcase

      // loop finished: release the counter and the interrupt hold
      // execLast marks the final execution of any instruction
      if (execLast) begin
         s_d.armed   = 1'b0;
         s_d.irqHold = 1'b0;
      end

      // ready follows the next state, so it is never a cycle late
      s_d.ready = (s_d.state == ST_IDLE);
   end

   // ************************************************************
   // state register
   // ************************************************************

   // every reset field is a constant; the release edge sees a clean struct
   // the core starts ready, so the first instruction can go at once
   // reset clears everything but ready, the repeat counter among it
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q       <= '0;
         s_q.state <= ST_IDLE;
         s_q.aux   <= {NUM_AUX{AUX_RST}};
         s_q.ptr   <= PTR_RST;
         s_q.page  <= PAGE_RST;
         s_q.cnt   <= CNT_RST;
         s_q.ready <= READY_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ************************************************************
   // outputs, all straight from the state register
   // ************************************************************
   // no logic between the register and the pins: clean one-cycle pulses
   assign instrReady = s_q.ready;
   assign progReq    = s_q.progReq;
   assign dataReq    = s_q.dataReq;
   assign opnd       = s_q.opnd;
   assign irqHold    = s_q.irqHold;
   assign prdata     = s_q.prdata;
   assign pready     = s_q.pready;
   assign pslverr    = s_q.pslverr;

endmodule // oar_operand_addressing

// >>> oar_pkg.sv
/*
 * oar_pkg: constants, enumerations and carrier structs for the operand
 * addressing and repeat block.
 * Assumes a 16-bit data path, an APB register port with 32-bit data and
 * a 12-bit byte address, and memories that answer with a valid strobe.
 */
package oar_pkg;

   // ************************************************************
   // widths and fields
   // ************************************************************
   localparam int unsigned DATA_W    = 16;
   localparam int unsigned NUM_AUX   = 8;
   localparam int unsigned PTR_W     = 3;
   localparam int unsigned PAGE_W    = 9;
   localparam int unsigned OFS_W     = 7;   // direct offset in the word
   localparam int unsigned SIMM_W    = 8;   // short immediate field
   localparam int unsigned PADDR_W   = 12;
   localparam int unsigned INDEX_REG = 0;   // aux 0 is the index register

   // ************************************************************
   // register map (byte addresses) and status layout
   // ************************************************************
   localparam logic [PADDR_W-1:0] AUX_BASE_OFS = 12'h000; // 8 words
   localparam logic [PADDR_W-1:0] PTR_OFS      = 12'h020;
   localparam logic [PADDR_W-1:0] PAGE_OFS     = 12'h024;
   localparam logic [PADDR_W-1:0] STAT_OFS     = 12'h028;
   localparam int unsigned STAT_CNT_LSB   = 0;   // repeat counter [15:0]
   localparam int unsigned STAT_ARMED_BIT = 16;
   localparam int unsigned STAT_BUSY_BIT  = 17;
   localparam int unsigned STAT_HOLD_BIT  = 18;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [DATA_W-1:0] AUX_RST   = 16'h0000;
   localparam logic [DATA_W-1:0] CNT_RST   = 16'h0000;
   localparam logic [PTR_W-1:0]  PTR_RST   = 3'h0;
   localparam logic [PAGE_W-1:0] PAGE_RST  = 9'h000;
   localparam logic              READY_RST = 1'b1;

   // ************************************************************
   // enumerations
   // ************************************************************
   typedef enum logic [2:0] {
      MODE_DIRECT, MODE_INDIRECT, MODE_SHORT, MODE_LONG, MODE_REG
   } oar_mode_t;

   typedef enum logic [2:0] {
      UPD_NONE, UPD_INC, UPD_DEC, UPD_ADD_IDX, UPD_SUB_IDX,
      UPD_REV_INC, UPD_REV_DEC
   } oar_upd_t;

   typedef enum logic [1:0] {
      ST_IDLE, ST_LONG, ST_RPTMEM, ST_REPEAT
   } oar_fsm_t;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic              valid;
      oar_mode_t         mode;
      logic [DATA_W-1:0] word;      // first program word
      oar_upd_t          upd;       // indirect update variant
      logic              loadPtr;   // load pointer after the access
      logic [PTR_W-1:0]  nextPtr;
      logic              isRepeat;  // this is the repeat instruction
      logic              tableOp;   // step address by one per iteration
      logic              implied;   // register mode: use current aux
      logic [PTR_W-1:0]  regSel;    // register mode: explicit aux
   } oar_instr_t;

   typedef struct packed {
      logic              valid;
      logic              isAddr;    // 1: value is an address, 0: data
      logic [DATA_W-1:0] value;
      logic              last;      // final execution of this instruction
   } oar_opnd_t;

   typedef struct packed {
      logic              valid;
      logic [DATA_W-1:0] addr;
   } oar_memreq_t;

   typedef struct packed {
      logic              valid;
      logic [DATA_W-1:0] data;
   } oar_word_t;

   typedef struct packed {
      oar_fsm_t                        state;
      logic [NUM_AUX-1:0][DATA_W-1:0] aux;
      logic [PTR_W-1:0]                ptr;
      logic [PAGE_W-1:0]               page;
      logic [DATA_W-1:0]               cnt;
      logic                            armed;
      logic                            irqHold;
      logic                            ready;
      oar_instr_t                      cur;
      logic [DATA_W-1:0]               tblAddr;
      oar_opnd_t                       opnd;
      logic                            progReq;
      oar_memreq_t                     dataReq;
      logic                            pready;
      logic [31:0]                     prdata;
      logic                            pslverr;
   } oar_state_t;

endpackage

// >>> oar_checker.sv
/* oar_checker: port assertions for the operand addressing block.
   assumes binding to oar_operand_addressing, one clock domain. */
`timescale 1ns/10ps
module oar_checker (
   input wire logic                 sys_clk,
   input wire logic                 rst_b,
   input wire oar_pkg::oar_instr_t  instr,
   input wire logic                 instrReady,
   input wire logic                 progReq,
   input wire oar_pkg::oar_word_t   progWord,
   input wire oar_pkg::oar_memreq_t dataReq,
   input wire oar_pkg::oar_opnd_t   opnd,
   input wire logic                 irqHold,
   input wire logic                 pready,
   input wire logic                 pslverr
);
   import oar_pkg::*;
   // ********************
   // properties
   // ********************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // an instruction is taken only where both sides agree
   wire take = instr.valid && instrReady;
   wire plain = take && !instr.isRepeat;
   a_long_fetch: assert property (
      plain && instr.mode == MODE_LONG |=> progReq)
      else $error("no second word fetch");
   a_long_value: assert property (
      progWord.valid |=> opnd.valid && opnd.value == $past(progWord.data))
      else $error("long operand differs from second word");
   a_short_value: assert property (
      plain && instr.mode == MODE_SHORT |=> opnd.valid && !opnd.isAddr
      && opnd.value == {8'h00, $past(instr.word[7:0])})
      else $error("short operand wrong");
   a_direct_offset: assert property (
      plain && instr.mode == MODE_DIRECT |=> opnd.valid && opnd.isAddr
      && opnd.value[6:0] == $past(instr.word[6:0]))
      else $error("direct offset wrong");
   a_repeat_hold: assert property (
      take && instr.isRepeat |=> irqHold && !opnd.valid)
      else $error("repeat decode did not hold interrupts");
   a_repeat_read: assert property (
      take && instr.isRepeat && (instr.mode == MODE_DIRECT
      || instr.mode == MODE_INDIRECT) |=> dataReq.valid)
      else $error("repeat count not read from memory");
   a_hold_stays: assert property (
      opnd.valid && !opnd.last |-> irqHold)
      else $error("hold dropped inside the loop");
   a_hold_end: assert property (
      $fell(irqHold) |-> opnd.valid && opnd.last)
      else $error("hold dropped before last execution");
   a_loop_back: assert property (
      opnd.valid && !opnd.last |=> opnd.valid)
      else $error("repeat iteration gap");
   a_loop_refuse: assert property (
      opnd.valid && !opnd.last |-> !instrReady)
      else $error("instruction accepted during loop");
   // main scenarios seen
   c_long: cover property (progReq);
   c_loop: cover property (opnd.valid && !opnd.last);
   c_err: cover property (pready && pslverr);
endmodule // oar_checker

bind oar_operand_addressing oar_checker u_chk (.sys_clk(sys_clk),
   .rst_b(rst_b), .instr(instr), .instrReady(instrReady),
   .progReq(progReq), .progWord(progWord), .dataReq(dataReq),
   .opnd(opnd), .irqHold(irqHold), .pready(pready), .pslverr(pslverr));

// >>> oar_mem_model.sv
/* oar_mem_model: program and data memory answering single reads.
   assumes requests are one-cycle pulses; lat sets the answer delay. */
`timescale 1ns/10ps
module oar_mem_model (
   input wire logic               sys_clk,
   input wire logic               rst_b,
   input wire logic               progReq,
   input wire oar_pkg::oar_memreq_t dataReq,
   input wire logic [3:0]         lat,
   input wire logic [15:0]        progData,
   input wire logic [15:0]        memData,
   output oar_pkg::oar_word_t     progWord,
   output oar_pkg::oar_word_t     dataRd
);
   import oar_pkg::*;
   logic [3:0] progCnt_q;
   logic [3:0] dataCnt_q;
   // idle lines flip between the last word and its inverse each cycle, so stale data never holds still
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         progCnt_q <= 4'h0;
         dataCnt_q <= 4'h0;
         progWord  <= '0;
         dataRd    <= '0;
      end else begin
         progWord.valid <= progCnt_q == 4'h1;
         progWord.data  <= progCnt_q == 4'h1 ? progData : ~progWord.data;
         dataRd.valid   <= dataCnt_q == 4'h1;
         dataRd.data    <= dataCnt_q == 4'h1 ? memData : ~dataRd.data;
         progCnt_q <= progReq ? lat : progCnt_q - 4'(progCnt_q != 4'h0);
         dataCnt_q <= dataReq.valid ? lat : dataCnt_q - 4'(dataCnt_q != 4'h0);
      end
   end
endmodule // oar_mem_model

// >>> testbench.sv
/* testbench: drives instructions and APB accesses, checks operands.
   assumes one-wait-state APB and the memory model on the far side. */
`timescale 1ns/10ps
module testbench;
   import oar_pkg::*;
   logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, er;
   logic instrReady, progReq, irqHold;
   logic [PADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] progData, memData, a, x;
   logic [3:0] lat;
   oar_instr_t instr, t;
   oar_word_t progWord, dataRd;
   oar_memreq_t dataReq;
   oar_opnd_t opnd;
   oar_opnd_t q[$];
   int miscompares, comparisons, k;

   oar_operand_addressing DUT (.sys_clk(sys_clk), .rst_b(rst_b),
      .instr(instr), .instrReady(instrReady), .progReq(progReq),
      .progWord(progWord), .dataReq(dataReq), .dataRd(dataRd),
      .opnd(opnd), .irqHold(irqHold), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   oar_mem_model u_mem (.sys_clk(sys_clk), .rst_b(rst_b),
      .progReq(progReq), .dataReq(dataReq), .lat(lat),
      .progData(progData), .memData(memData), .progWord(progWord),
      .dataRd(dataRd));

   // ********************
   // helpers
   // ********************
   function automatic logic [15:0] mir(input logic [15:0] v);
      for (int i = 0; i < 16; i++) mir[i] = v[15-i];
   endfunction
   function automatic oar_instr_t mk(oar_mode_t m, logic [15:0] w,
                                     oar_upd_t u);
      oar_instr_t r;
      r = '0;
      r.valid = 1'b1;
      r.mode = m;
      r.word = w;
      r.upd = u;
      return r;
   endfunction
   // request held until the edge that samples pready high
   task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task issue(input oar_instr_t i);
      instr <= i;
      do @(posedge sys_clk); while (instrReady !== 1'b1);
   endtask
   task waitq(input int n);
      instr <= '0;
      do @(posedge sys_clk); while (q.size() < n);
      @(posedge sys_clk);
   endtask
   task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      comparisons++;
      if (got !== ex) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task chkop(input string nm, input logic l, input logic ia,
              input logic [15:0] v);
      oar_opnd_t o;
      o = q.pop_front();
      chk(nm, {14'h0, l, ia, v}, {14'h0, o.last, o.isAddr, o.value});
   endtask
   task complete_run;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ********************
   // stimulus
   // ********************
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) if (opnd.valid === 1'b1) q.push_back(opnd);
   // the whole run needs well under a tenth of this span
   initial begin
      #2000000;
      miscompares++;
      complete_run;
   end
   initial begin
      {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
      instr = '0;
      progData = 16'hbeef;
      memData = 16'h0001;
      lat = 4'h1;
      repeat (6) @(posedge sys_clk);
      rst_b <= 1'b1;
      apb(1'b0, STAT_OFS, 32'h0);
      chk("status", 32'h0, rd);
      apb(1'b1, AUX_BASE_OFS, 32'h4);
      apb(1'b1, AUX_BASE_OFS + 12'h00c, 32'h100);
      apb(1'b1, AUX_BASE_OFS + 12'h014, 32'ha5a);
      apb(1'b1, AUX_BASE_OFS + 12'h01c, 32'h7777);
      apb(1'b1, PTR_OFS, 32'h3);
      apb(1'b1, PAGE_OFS, 32'h5);
      // all indirect updates in enum order on aux 3, index 4
      a = 16'h0100;
      x = 16'h0004;
      for (k = 0; k < 7; k++) begin
         issue(mk(MODE_INDIRECT, 16'h0, oar_upd_t'(k)));
         waitq(1);
         chkop("indirect address", 1'b1, 1'b1, a);
         case (oar_upd_t'(k))
            UPD_INC:     a = a + 16'h1;
            UPD_DEC:     a = a - 16'h1;
            UPD_ADD_IDX: a = a + x;
            UPD_SUB_IDX: a = a - x;
            UPD_REV_INC: a = mir(mir(a) + mir(x));
            UPD_REV_DEC: a = mir(mir(a) - mir(x));
            default: ;
         endcase
         apb(1'b0, AUX_BASE_OFS + 12'h00c, 32'h0);
         chk("aux update", {16'h0, a}, rd);
      end
      t = mk(MODE_INDIRECT, 16'h0, UPD_NONE);
      t.loadPtr = 1'b1;
      t.nextPtr = 3'h5;
      issue(t);
      t.loadPtr = 1'b0;
      issue(t);
      waitq(2);
      chkop("old pointer", 1'b1, 1'b1, a);
      chkop("new pointer", 1'b1, 1'b1, 16'h0a5a);
      // register mode, implied and explicit, back to back
      t = mk(MODE_REG, 16'h0, UPD_NONE);
      t.implied = 1'b1;
      issue(t);
      t.implied = 1'b0;
      t.regSel = 3'h7;
      issue(t);
      waitq(2);
      chkop("implied reg", 1'b1, 1'b0, 16'h0a5a);
      chkop("explicit reg", 1'b1, 1'b0, 16'h7777);
      issue(mk(MODE_DIRECT, 16'h0f92, UPD_NONE));
      issue(mk(MODE_SHORT, 16'h12ab, UPD_NONE));
      waitq(2);
      chkop("direct", 1'b1, 1'b1, 16'h0292);
      chkop("short", 1'b1, 1'b0, 16'h00ab);
      // second word answered promptly, then slowly
      for (k = 1; k < 5; k += 3) begin
         lat <= 4'(k);
         issue(mk(MODE_LONG, 16'h3456, UPD_NONE));
         waitq(1);
         chkop("long", 1'b1, 1'b0, 16'hbeef);
      end
      t = mk(MODE_SHORT, 16'h0002, UPD_NONE);
      t.isRepeat = 1'b1;
      issue(t);
      issue(mk(MODE_REG, 16'h0, UPD_NONE)); // regSel 0: index register
      waitq(3);
      for (k = 0; k < 3; k++)
         chkop("repeat reg", k == 2, 1'b0, 16'h0004);
      chk("hold after loop", 32'h0, {31'h0, irqHold});
      t = mk(MODE_DIRECT, 16'h0010, UPD_NONE);
      t.isRepeat = 1'b1;
      issue(t);
      t.isRepeat = 1'b0;
      t.tableOp = 1'b1;
      issue(t);
      waitq(2);
      chkop("table first", 1'b0, 1'b1, 16'h0290);
      chkop("table next", 1'b1, 1'b1, 16'h0291);
      apb(1'b0, 12'h100, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, er});
      complete_run;
   end
endmodule // testbench
